// ### hw/aap_port_diag_regs.sv
// register slice for audio port format, channel state, level and dc load checks
`timescale 1ns/1ps
`include "aap_cfg.svh"

module aap_port_diag_regs (
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire logic [7:0]           regAddr,
	input  wire logic [7:0]           regWrData,
	input  wire logic                 regWrEn,
	input  wire logic                 regRdEn,
	output logic      [7:0]           regRdData,
	output logic                      regRdValid,
	input  wire logic                 tdmEightSlot,
	input  wire logic                 channelFault,
	input  wire logic                 groundShortSeen,
	input  wire logic                 supplyShortSeen,
	input  wire logic                 openLoadSeen,
	input  wire logic                 shortedLoadSeen,
	input  wire aap_pkg::aap_state_t  channelStateNow,
	output aap_pkg::aap_rate_t        sampleRateSelect,
	output logic                      sampleRateValid,
	output logic      [2:0]           slotSelect,
	output logic                      slotValid,
	output aap_pkg::aap_fmt_t         inputFormat,
	output logic                      formatValid,
	output aap_pkg::aap_state_t       outputStateSelect,
	output logic      [7:0]           outputLevelCode,
	output logic                      levelMute,
	output logic                      loadCheckCancel,
	output logic                      rampDoubling,
	output logic                      settleDoubling,
	output logic                      lineOutCheckOn,
	output logic                      autoCheckStart,
	output logic      [3:0]           shortLoadLimit
);

	// ****************************************
	// register storage
	// ****************************************
	logic [7:0] portFmt_q, portFmt_d;
	logic [7:0] stateCmd_q, stateCmd_d;
	logic [7:0] level_q, level_d;
	logic [7:0] checkA_q, checkA_d;
	logic [7:0] checkB_q, checkB_d;
	logic [3:0] result_q;
	logic [1:0] stateSeen_q;
	logic       faultPrev_q;
	logic [7:0] rdData_q, rdData_d;
	logic       rdValid_q;
	logic       autoStart_q, autoStart_d;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	// ****************************************
	// write decode
	// ****************************************
	wire wrFmt    = regWrEn && hit(regAddr, `AAP_ADDR_PORT_FMT);
	wire wrState  = regWrEn && hit(regAddr, `AAP_ADDR_STATE_CMD);
	wire wrLevel  = regWrEn && hit(regAddr, `AAP_ADDR_LEVEL);
	wire wrCheckA = regWrEn && hit(regAddr, `AAP_ADDR_CHECK_A);
	wire wrCheckB = regWrEn && hit(regAddr, `AAP_ADDR_CHECK_B);

	// reserved bits stay writable; host keeps their reset values
	assign portFmt_d  = wrFmt    ? regWrData : portFmt_q;
	assign stateCmd_d = wrState  ? regWrData : stateCmd_q;
	assign level_d    = wrLevel  ? regWrData : level_q;
	assign checkA_d   = wrCheckA ? regWrData : checkA_q;
	assign checkB_d   = wrCheckB ? regWrData : checkB_q;

	// ****************************************
	// automatic diagnostic trigger
	// ****************************************
	wire leaveHiz   = wrState && (stateCmd_q[7:6] == aap_pkg::ST_HIZ)
		&& (regWrData[7:6] != aap_pkg::ST_HIZ);
	wire faultRise  = channelFault && !faultPrev_q;
	// an abort in force also holds off new automatic runs
	assign autoStart_d = (leaveHiz || faultRise) && !checkA_q[`AAP_BIT_SKIP]
		&& !checkA_q[`AAP_BIT_CANCEL];

	// ****************************************
	// read mux, unmapped reads return zero
	// ****************************************
	wire [7:0] resultByte = {result_q, 4'h0};
	wire [7:0] seenByte   = {stateSeen_q, 6'h00};
	assign rdData_d =
		hit(regAddr, `AAP_ADDR_PORT_FMT)   ? portFmt_q  :
		hit(regAddr, `AAP_ADDR_STATE_CMD)  ? stateCmd_q :
		hit(regAddr, `AAP_ADDR_LEVEL)      ? level_q    :
		hit(regAddr, `AAP_ADDR_CHECK_A)    ? checkA_q   :
		hit(regAddr, `AAP_ADDR_CHECK_B)    ? checkB_q   :
		hit(regAddr, `AAP_ADDR_RESULT_A)   ? resultByte :
		hit(regAddr, `AAP_ADDR_STATE_SEEN) ? seenByte   : 8'h00;

	// ****************************************
	// field decode
	// ****************************************
	wire [1:0] rateField = portFmt_q[7:6];
	wire [2:0] slotField = portFmt_q[5:3];
	wire [2:0] fmtField  = portFmt_q[2:0];
	wire rateOk = (rateField != aap_pkg::RATE_RSVD);
	// upper four slots exist only in eight-slot tdm
	wire slotOk = (slotField < `AAP_SLOT_TDM8_FIRST) || tdmEightSlot;
	wire fmtOk  = (fmtField != aap_pkg::FMT_RSVD);
	wire muteByLevel = (level_q < `AAP_LEVEL_MUTE_BELOW);

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			portFmt_q  <= `AAP_RST_PORT_FMT;
			stateCmd_q <= `AAP_RST_STATE_CMD;
			level_q    <= `AAP_RST_LEVEL;
			checkA_q   <= `AAP_RST_CHECK_A;
			checkB_q   <= `AAP_RST_CHECK_B;
		end else begin
			portFmt_q  <= portFmt_d;
			stateCmd_q <= stateCmd_d;
			level_q    <= level_d;
			checkA_q   <= checkA_d;
			checkB_q   <= checkB_d;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			result_q    <= 4'h0;
			stateSeen_q <= `AAP_RST_STATE_SEEN;
			faultPrev_q <= 1'b0;
			autoStart_q <= 1'b0;
			rdData_q    <= 8'h00;
			rdValid_q   <= 1'b0;
		end else begin
			result_q    <= {groundShortSeen, supplyShortSeen,
				openLoadSeen, shortedLoadSeen};
			stateSeen_q <= channelStateNow;
			faultPrev_q <= channelFault;
			autoStart_q <= autoStart_d;
			rdData_q    <= regRdEn ? rdData_d : rdData_q;
			rdValid_q   <= regRdEn;
		end
	end

	// outputs decoded once a cycle so each leaves a flip-flop
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sampleRateValid <= 1'b1;
			slotValid       <= 1'b1;
			formatValid     <= 1'b1;
			levelMute       <= 1'b0;
		end else begin
			sampleRateValid <= rateOk;
			slotValid       <= slotOk;
			formatValid     <= fmtOk;
			levelMute       <= muteByLevel;
		end
	end

	assign regRdData  = rdData_q;
	assign regRdValid = rdValid_q;
	assign sampleRateSelect  = aap_pkg::aap_rate_t'(rateField);
	assign slotSelect        = slotField;
	assign inputFormat       = aap_pkg::aap_fmt_t'(fmtField);
	assign outputStateSelect = aap_pkg::aap_state_t'(stateCmd_q[7:6]);
	assign outputLevelCode   = level_q;
	assign loadCheckCancel   = checkA_q[`AAP_BIT_CANCEL];
	assign rampDoubling      = checkA_q[`AAP_BIT_RAMP2X];
	assign settleDoubling    = checkA_q[`AAP_BIT_SETTLE2X];
	assign lineOutCheckOn    = checkA_q[`AAP_BIT_LINEOUT];
	assign autoCheckStart    = autoStart_q;
	assign shortLoadLimit    = checkB_q[7:4];

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_leave_hiz;
		wrState && stateCmd_q[7:6] == 2'h1 && regWrData[7:6] != 2'h1;
	endsequence
	sequence s_fault_rise;
		channelFault && !faultPrev_q;
	endsequence
	sequence s_may_run;
		!checkA_q[0] && !checkA_q[7];
	endsequence
	sequence s_ro_write;
		regWrEn && (regAddr == `AAP_ADDR_RESULT_A || regAddr == `AAP_ADDR_STATE_SEEN);
	endsequence
	sequence s_result_read;
		regRdEn && regAddr == `AAP_ADDR_RESULT_A;
	endsequence
	sequence s_seen_read;
		regRdEn && regAddr == `AAP_ADDR_STATE_SEEN;
	endsequence

	// ****************************************
	// port format checks
	// ****************************************
	a_rate_reserved_flag: assert property (
		wrFmt && regWrData[7:6] == 2'h3 |-> ##2 !sampleRateValid)
		else $error("reserved rate not flagged");
	a_rate_ok_flag: assert property (
		wrFmt && regWrData[7:6] != 2'h3 |-> ##2 sampleRateValid)
		else $error("usable rate flagged invalid");
	a_rate_field_write: assert property (
		wrFmt |=> sampleRateSelect == $past(regWrData[7:6]))
		else $error("rate field not stored");
	a_rate_hold: assert property (
		!wrFmt |=> $stable(sampleRateSelect))
		else $error("rate field changed without write");
	a_low_slot_ok: assert property (
		!portFmt_q[5] |=> slotValid)
		else $error("low slot flagged invalid");
	a_upper_slot_tdm8: assert property (
		portFmt_q[5] && !tdmEightSlot |=> !slotValid)
		else $error("upper slot accepted outside tdm8");
	a_upper_slot_ok: assert property (
		portFmt_q[5] && tdmEightSlot |=> slotValid)
		else $error("upper slot refused in tdm8");
	a_slot_field_write: assert property (
		wrFmt |=> slotSelect == $past(regWrData[5:3]))
		else $error("slot field not stored");
	a_slot_hold: assert property (
		!wrFmt |=> $stable(slotSelect))
		else $error("slot field changed without write");
	a_rj_format_ok: assert property (
		wrFmt && !regWrData[2] |-> ##2 formatValid)
		else $error("right-justified format flagged invalid");
	a_framed_format_ok: assert property (
		wrFmt && regWrData[2] && regWrData[1:0] != 2'h3 |-> ##2 formatValid)
		else $error("framed format flagged invalid");
	a_format_reserved: assert property (
		wrFmt |=> (inputFormat == $past(regWrData[2:0]))
			##1 (formatValid == ($past(regWrData[2:0], 2) != 3'h7)))
		else $error("format field or validity wrong");
	a_format_hold: assert property (
		!wrFmt |=> $stable(inputFormat))
		else $error("format field changed without write");

	// ****************************************
	// state and level checks
	// ****************************************
	a_state_cmd_write: assert property (
		wrState |=> outputStateSelect == $past(regWrData[7:6]))
		else $error("state command not stored");
	a_state_low_bits: assert property (
		wrState |=> stateCmd_q[5:0] == $past(regWrData[5:0]))
		else $error("state low bits not stored");
	a_state_hold: assert property (
		!wrState |=> $stable(outputStateSelect))
		else $error("state command changed without write");
	a_level_write: assert property (
		wrLevel |=> outputLevelCode == $past(regWrData))
		else $error("level code not stored");
	a_level_hold: assert property (
		!wrLevel |=> $stable(outputLevelCode))
		else $error("level code changed without write");
	a_level_mute: assert property (
		wrLevel |-> ##2 (levelMute == ($past(regWrData, 2) < 8'h07)))
		else $error("level mute wrong");
	a_level_floor: assert property (
		outputLevelCode >= 8'h07 |=> !levelMute)
		else $error("audible level muted");
	a_level_below: assert property (
		outputLevelCode < 8'h07 |=> levelMute)
		else $error("level below floor not muted");

	// ****************************************
	// load check control checks
	// ****************************************
	a_cancel_hold: assert property (
		loadCheckCancel && !wrCheckA |=> loadCheckCancel)
		else $error("cancel dropped without host write");
	a_cancel_set: assert property (
		wrCheckA |=> loadCheckCancel == $past(regWrData[7]))
		else $error("cancel bit not stored");
	a_cancel_release: assert property (
		loadCheckCancel && wrCheckA && !regWrData[7] |=> !loadCheckCancel)
		else $error("cancel not released by host");
	a_ramp_double: assert property (
		wrCheckA |=> rampDoubling == $past(regWrData[6]))
		else $error("ramp doubling not stored");
	a_ramp_hold: assert property (
		!wrCheckA |=> $stable(rampDoubling))
		else $error("ramp doubling changed without write");
	a_settle_double: assert property (
		wrCheckA |=> settleDoubling == $past(regWrData[5]))
		else $error("settle doubling not stored");
	a_settle_hold: assert property (
		!wrCheckA |=> $stable(settleDoubling))
		else $error("settle doubling changed without write");
	a_lineout_enable: assert property (
		wrCheckA |=> lineOutCheckOn == $past(regWrData[1]))
		else $error("line-out enable not stored");
	a_lineout_hold: assert property (
		!wrCheckA |=> $stable(lineOutCheckOn))
		else $error("line-out enable changed without write");
	a_skip_bit_write: assert property (
		wrCheckA |=> checkA_q[0] == $past(regWrData[0]))
		else $error("bypass bit not stored");
	a_threshold: assert property (
		wrCheckB |=> shortLoadLimit == $past(regWrData[7:4]))
		else $error("threshold not stored");
	a_threshold_hold: assert property (
		!wrCheckB |=> $stable(shortLoadLimit))
		else $error("threshold changed without write");
	a_limit_low_bits: assert property (
		wrCheckB |=> checkB_q[3:0] == $past(regWrData[3:0]))
		else $error("threshold low bits not stored");

	// ****************************************
	// automatic run checks
	// ****************************************
	a_auto_start: assert property (
		s_leave_hiz and s_may_run |=> autoCheckStart)
		else $error("automatic run missed on leaving hi-z");
	a_auto_fault: assert property (
		s_fault_rise and s_may_run |=> autoCheckStart)
		else $error("automatic run missed after fault");
	a_auto_skip: assert property (
		checkA_q[0] |=> !autoCheckStart)
		else $error("automatic run despite bypass");
	a_auto_cancel: assert property (
		checkA_q[7] |=> !autoCheckStart)
		else $error("automatic run despite cancel");
	a_auto_no_cause: assert property (
		!wrState && !channelFault |=> !autoCheckStart)
		else $error("automatic run without cause");

	// ****************************************
	// report checks
	// ****************************************
	// reports lag their inputs one edge, the read adds another
	a_result_track: assert property (
		s_result_read |=> regRdData[7] == $past(result_q[3]) && regRdData[3:0] == 4'h0)
		else $error("result read wrong");
	a_result_bits: assert property (
		s_result_read |=> regRdData[7:4] == $past({groundShortSeen, supplyShortSeen,
			openLoadSeen, shortedLoadSeen}, 2))
		else $error("result flags not reported");
	a_state_seen_read: assert property (
		s_seen_read |=> regRdData[7:6] == $past(channelStateNow, 2) && regRdData[5:0] == 6'h00)
		else $error("present state not reported");
	a_readonly_ignored: assert property (
		s_ro_write |=> $stable(portFmt_q) && $stable(stateCmd_q) && $stable(level_q)
			&& $stable(checkA_q) && $stable(checkB_q))
		else $error("write to read-only register changed storage");

endmodule // aap_port_diag_regs

// ### hw/aap_cfg.svh
// offsets, field positions, reset values and limits of the audio port and diagnostic registers
`ifndef AAP_CFG_SVH
`define AAP_CFG_SVH

`define AAP_ADDR_PORT_FMT    8'h03
`define AAP_ADDR_STATE_CMD   8'h04
`define AAP_ADDR_LEVEL       8'h05
`define AAP_ADDR_CHECK_A     8'h09
`define AAP_ADDR_CHECK_B     8'h0a
`define AAP_ADDR_RESULT_A    8'h0c
`define AAP_ADDR_STATE_SEEN  8'h0f

`define AAP_RST_PORT_FMT     8'h04
`define AAP_RST_STATE_CMD    8'h55
`define AAP_RST_LEVEL        8'hcf
`define AAP_RST_CHECK_A      8'h00
`define AAP_RST_CHECK_B      8'h11
`define AAP_RST_STATE_SEEN   2'h1

`define AAP_BIT_CANCEL       7
`define AAP_BIT_RAMP2X       6
`define AAP_BIT_SETTLE2X     5
`define AAP_BIT_LINEOUT      1
`define AAP_BIT_SKIP         0

`define AAP_LEVEL_MUTE_BELOW 8'h07
`define AAP_SLOT_TDM8_FIRST  3'h4

`endif

// ### hw/aap_pkg.sv
// types shared by the audio port and diagnostic register slice
package aap_pkg;

	typedef enum logic [1:0] {
		RATE_44K1 = 2'h0,
		RATE_48K  = 2'h1,
		RATE_96K  = 2'h2,
		RATE_RSVD = 2'h3
	} aap_rate_t;

	typedef enum logic [2:0] {
		FMT_RJ24  = 3'h0,
		FMT_RJ20  = 3'h1,
		FMT_RJ18  = 3'h2,
		FMT_RJ16  = 3'h3,
		FMT_I2S   = 3'h4,
		FMT_LJ    = 3'h5,
		FMT_DSP   = 3'h6,
		FMT_RSVD  = 3'h7
	} aap_fmt_t;

	typedef enum logic [1:0] {
		ST_PLAY = 2'h0,
		ST_HIZ  = 2'h1,
		ST_MUTE = 2'h2,
		ST_DIAG = 2'h3
	} aap_state_t;

endpackage

// ### verif/aap_host_model.sv
// host model driving the register strobe port of the slice
`timescale 1ns/1ps

module aap_host_model (
	input  wire logic       sys_clk,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	output logic            regWrEn,
	output logic            regRdEn,
	input  wire logic [7:0] regRdData,
	input  wire logic       regRdValid
);
	// ****************
	// bus cycles
	// ****************
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end

	// data inverted once released so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge sys_clk);
		regWrEn = 1'b0;
		regWrData = ~d;
		repeat (2) @(negedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge sys_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge sys_clk);
		regRdEn = 1'b0;
		v = regRdValid;
		d = regRdData;
	endtask
endmodule // aap_host_model

// ### verif/tb_top.sv
// self-checking bench for the audio port and load check register slice
`timescale 1ns/1ps

module tb_top;
	logic                sys_clk, sys_rst, tdmEightSlot, channelFault;
	logic [3:0]          flags;
	aap_pkg::aap_state_t channelStateNow;
	logic [7:0]          regAddr, regWrData, regRdData;
	logic                regWrEn, regRdEn, regRdValid;
	aap_pkg::aap_rate_t  sampleRateSelect;
	aap_pkg::aap_fmt_t   inputFormat;
	aap_pkg::aap_state_t outputStateSelect;
	logic [2:0]          slotSelect;
	logic [7:0]          outputLevelCode;
	logic [3:0]          shortLoadLimit;
	logic                sampleRateValid, slotValid, formatValid, levelMute;
	logic                loadCheckCancel, rampDoubling, settleDoubling, lineOutCheckOn;
	logic                autoCheckStart;
	int                  miscompares, numChecks, cycles, autoCount;

	aap_port_diag_regs u_aap_port_diag_regs (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .regRdValid(regRdValid), .tdmEightSlot(tdmEightSlot),
		.channelFault(channelFault), .groundShortSeen(flags[3]), .supplyShortSeen(flags[2]),
		.openLoadSeen(flags[1]), .shortedLoadSeen(flags[0]), .channelStateNow(channelStateNow),
		.sampleRateSelect(sampleRateSelect), .sampleRateValid(sampleRateValid),
		.slotSelect(slotSelect), .slotValid(slotValid), .inputFormat(inputFormat),
		.formatValid(formatValid), .outputStateSelect(outputStateSelect),
		.outputLevelCode(outputLevelCode), .levelMute(levelMute),
		.loadCheckCancel(loadCheckCancel), .rampDoubling(rampDoubling),
		.settleDoubling(settleDoubling), .lineOutCheckOn(lineOutCheckOn),
		.autoCheckStart(autoCheckStart), .shortLoadLimit(shortLoadLimit));

	aap_host_model u_aap_host_model (.sys_clk(sys_clk), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .regRdValid(regRdValid));

	// ****************
	// checking helpers
	// ****************
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		numChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		u_aap_host_model.rd(a, d, v);
		check("read valid", 8'(v), 8'h01);
		check("read data", d, exp);
	endtask

	task automatic completeRun();
		if (miscompares == 0 && numChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic resetRun();
		rdchk(8'h03, 8'h04);
		rdchk(8'h04, 8'h55);
		rdchk(8'h05, 8'hcf);
		rdchk(8'h09, 8'h00);
		rdchk(8'h0a, 8'h11);
		rdchk(8'h0c, 8'h00);
		rdchk(8'h0f, 8'h40);
		check("format", 8'(inputFormat), 8'h04);
		check("flags", {5'h00, sampleRateValid, slotValid, formatValid}, 8'h07);
		check("mute", 8'(levelMute), 8'h00);
	endtask

	// reserved codes written on purpose to see the valid flags drop
	task automatic formatRun();
		logic [2:0] c;
		for (int i = 0; i < 16; i++) begin
			tdmEightSlot = i[3];
			c = i[2:0];
			u_aap_host_model.wr(8'h03, {c[1:0], c, c});
			check("rate", 8'(sampleRateSelect), 8'(c[1:0]));
			check("rate ok", 8'(sampleRateValid), 8'(c[1:0] != 2'h3));
			check("slot", 8'(slotSelect), 8'(c));
			check("slot ok", 8'(slotValid), 8'(c < 3'h4 || i[3]));
			check("format", 8'(inputFormat), 8'(c));
			check("format ok", 8'(formatValid), 8'(c != 3'h7));
		end
		u_aap_host_model.wr(8'h03, 8'h04);
	endtask

	task automatic levelRun();
		logic [8:0] t [4] = '{9'h007, 9'h106, 9'h100, 9'h0ff};
		foreach (t[k]) begin
			u_aap_host_model.wr(8'h05, t[k][7:0]);
			check("level", outputLevelCode, t[k][7:0]);
			check("mute", 8'(levelMute), 8'(t[k][8]));
		end
	endtask

	task automatic autoRun();
		int base;
		for (int s = 3; s >= 0; s--) begin
			u_aap_host_model.wr(8'h04, {2'(s), 6'h15});
			check("state", 8'(outputStateSelect), 8'(s));
		end
		u_aap_host_model.wr(8'h04, 8'h55);
		base = autoCount;
		u_aap_host_model.wr(8'h04, 8'h15);
		check("auto leave hiz", 8'(autoCount - base), 8'h01);
		u_aap_host_model.wr(8'h04, 8'h55);
		u_aap_host_model.wr(8'h09, 8'h01);
		u_aap_host_model.wr(8'h04, 8'h15);
		channelFault = 1'b1;
		repeat (3) @(negedge sys_clk);
		channelFault = 1'b0;
		check("auto skipped", 8'(autoCount - base), 8'h01);
		u_aap_host_model.wr(8'h09, 8'h80);
		channelFault = 1'b1;
		repeat (3) @(negedge sys_clk);
		channelFault = 1'b0;
		check("auto cancelled", 8'(autoCount - base), 8'h01);
		u_aap_host_model.wr(8'h09, 8'h00);
		channelFault = 1'b1;
		repeat (3) @(negedge sys_clk);
		check("auto on fault", 8'(autoCount - base), 8'h02);
	endtask

	task automatic diagRun();
		u_aap_host_model.wr(8'h09, 8'he2);
		check("bits", {loadCheckCancel, rampDoubling, settleDoubling, lineOutCheckOn, 4'h0},
			8'hf0);
		rdchk(8'h09, 8'he2);
		u_aap_host_model.wr(8'h09, 8'h00);
		check("bits off", {loadCheckCancel, rampDoubling, settleDoubling, lineOutCheckOn, 4'h0},
			8'h00);
		u_aap_host_model.wr(8'h0a, 8'h91);
		check("short limit", 8'(shortLoadLimit), 8'h09);
		rdchk(8'h0a, 8'h91);
	endtask

	task automatic reportRun();
		flags = 4'ha;
		channelStateNow = aap_pkg::ST_MUTE;
		repeat (2) @(negedge sys_clk);
		rdchk(8'h0c, 8'ha0);
		rdchk(8'h0f, 8'h80);
		u_aap_host_model.wr(8'h0c, 8'hff);
		rdchk(8'h0a, 8'h91);
		flags = 4'h5;
		repeat (2) @(negedge sys_clk);
		rdchk(8'h0c, 8'h50);
		rdchk(8'h20, 8'h00);
	endtask

	// ****************
	// clock, reset, sequence
	// ****************
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (autoCheckStart === 1'b1) autoCount++;
		if (cycles == 3000) begin
			miscompares++;
			completeRun();
		end
	end

	initial begin
		sys_rst = 1'b1;
		tdmEightSlot = 1'b0;
		channelFault = 1'b0;
		flags = 4'h0;
		channelStateNow = aap_pkg::ST_HIZ;
		repeat (6) @(negedge sys_clk);
		sys_rst = 1'b0;
		resetRun();
		formatRun();
		levelRun();
		autoRun();
		diagRun();
		reportRun();
		completeRun();
	end
endmodule // tb_top
